// ---- logic/eba_pkg.sv ----
// constants and types shared by the expansion bus arbiter/target block
package eba_pkg;
    localparam int EBA_NUM_MASTERS = 3;
    localparam int EBA_NUM_REQ = 4;
    localparam int EBA_NUM_CS = 8;
    localparam logic [2:0] EBA_GNT_RST = 3'h7;
    localparam logic EBA_SHARED_OUT_RST = 1'h1;
    localparam logic EBA_WAIT_RST = 1'h1;
    // requester index of the shared request pin in internal mode
    localparam logic [1:0] EBA_SHARED_IDX = 2'h3;
    localparam logic [1:0] EBA_PTR_RST = 2'h0;
    typedef enum logic [1:0] {
        EBA_IDLE = 2'b00,
        EBA_OWNED = 2'b01,
        EBA_RELEASE = 2'b11
    } eba_arb_state_t;
    typedef enum logic [1:0] {
        EBA_T_IDLE = 2'b00,
        EBA_T_HOLD = 2'b01,
        EBA_T_READY = 2'b11
    } eba_tgt_state_t;
endpackage

// ---- logic/eba_sync_if.sv ----
// interface carrying synchronised pin levels inside eba_top, not passed between modules
`timescale 1ns/10ps
`default_nettype none
interface eba_sync_if;
    logic [eba_pkg::EBA_NUM_MASTERS-1:0] req_n;
    logic shared_in_n;
    logic target_select_n;
    logic burst;
    logic [eba_pkg::EBA_NUM_CS-1:0] cs_n;
    logic [3:0] be_n;
    modport src (output req_n, shared_in_n, target_select_n, burst, cs_n,
                 be_n);
    modport dst (input req_n, shared_in_n, target_select_n, burst, cs_n,
                 be_n);
endinterface
`default_nettype wire

// ---- logic/eba_pin_sync.sv ----
// two flip-flop synchroniser for all asynchronous expansion bus inputs
`timescale 1ns/10ps
`default_nettype none
module eba_pin_sync #(
    parameter int WIDTH = 14
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pins_in,
    input wire logic [WIDTH-1:0] reset_level,
    output logic [WIDTH-1:0] pins_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] seen_ff;

    // reset loads all ones: every synchronised pin is active low or idle high
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= pins_in;
            sync_ff <= meta_ff;
        end
    end

    // reset_level unused by flops under async reset; kept for constant idle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            seen_ff <= '0;
        end else begin
            seen_ff <= '1;
        end
    end

    assign pins_out = seen_ff & sync_ff | ~seen_ff & reset_level;
endmodule
`default_nettype wire

// ---- logic/eba_top.sv ----
// expansion bus arbiter and inbound target hold-off logic
// Behaviour
// - asserted request yields matching grant low
// - reset holds all three grants high
// - shared input: request or external grant
// - shared output resets high; grant or request
// - external mode enables pull-ups on requests
// - target select low starts inbound access
// - drive hold-off only while target selected
// - hold-off low until access can complete
// - inbound reads full word; lanes on writes
// - arbitrate only while outbound selects idle
`timescale 1ns/10ps
`default_nettype none
module eba_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic external_arbiter_mode,
    input wire logic [eba_pkg::EBA_NUM_MASTERS-1:0] master_bus_request_n,
    output logic [eba_pkg::EBA_NUM_MASTERS-1:0] master_bus_grant_n,
    output logic request_pullup_en,
    input wire logic shared_request_or_grant_in_n,
    output logic shared_grant_or_request_out_n,
    input wire logic own_bus_request,
    output logic own_bus_granted,
    input wire logic [eba_pkg::EBA_NUM_CS-1:0] outbound_chip_select_n,
    input wire logic target_select_n,
    input wire logic inbound_burst_flag,
    input wire logic inbound_write,
    input wire logic [3:0] byte_lane_enable_n,
    output logic inbound_start,
    output logic inbound_burst,
    output logic [3:0] inbound_lane_mask,
    input wire logic inbound_data_ready,
    output logic target_hold_off_n_out,
    output logic target_hold_off_n_oe
);
    import eba_pkg::*;

    // ==================================================
    // input synchronisation
    eba_sync_if syn ();
    logic [17:0] sync_q;

    // byte lanes are pins too, so they share the select's latency
    eba_pin_sync #(.WIDTH(18)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pins_in({byte_lane_enable_n, outbound_chip_select_n,
                  inbound_burst_flag, target_select_n,
                  shared_request_or_grant_in_n, master_bus_request_n}),
        .reset_level(18'h3FFFF),
        .pins_out(sync_q)
    );

    // external mode: pull-ups make the per-master requests read idle
    assign syn.req_n = external_arbiter_mode ? 3'h7 : sync_q[2:0];
    assign syn.shared_in_n = sync_q[3];
    assign syn.target_select_n = sync_q[4];
    assign syn.burst = sync_q[5];
    assign syn.cs_n = sync_q[13:6];
    assign syn.be_n = sync_q[17:14];
    assign request_pullup_en = external_arbiter_mode;

    // ==================================================
    // internal arbiter
    eba_arb_state_t arb_state_ff;
    logic [1:0] owner_ff;
    logic [1:0] ptr_ff;
    logic [EBA_NUM_REQ-1:0] req_vec;
    logic bus_quiet;
    logic [1:0] pick;
    logic pick_valid;

    // shared input acts as a fourth request only in internal mode
    assign req_vec = {~external_arbiter_mode & ~syn.shared_in_n,
                      ~syn.req_n};
    // ownership never changes mid outbound cycle
    assign bus_quiet = &syn.cs_n;

    // round-robin search starting after the last owner
    always_comb begin
        logic [1:0] idx;
        idx = 2'h0;
        pick = 2'h0;
        pick_valid = 1'b0;
        for (int i = 1; i <= EBA_NUM_REQ; i++) begin
            idx = 2'(ptr_ff + 2'(i));
            if (!pick_valid && req_vec[idx]) begin
                pick = idx;
                pick_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            arb_state_ff <= EBA_IDLE;
            owner_ff <= EBA_PTR_RST;
            ptr_ff <= EBA_PTR_RST;
        end else begin
            unique case (arb_state_ff)
                EBA_IDLE: begin
                    if (pick_valid && bus_quiet) begin
                        arb_state_ff <= EBA_OWNED;
                        owner_ff <= pick;
                        ptr_ff <= pick;
                    end
                end
                EBA_OWNED: begin
                    if (!req_vec[owner_ff]) begin
                        arb_state_ff <= EBA_RELEASE;
                    end
                end
                EBA_RELEASE: begin
                    // one dead cycle so two grants never overlap on the pins
                    arb_state_ff <= EBA_IDLE;
                end
                default: begin
                    arb_state_ff <= EBA_IDLE;
                end
            endcase
        end
    end

    // grant outputs: registered, high in reset
    logic [EBA_NUM_MASTERS-1:0] gnt_n_ff;
    logic shared_out_n_ff;
    logic granted;
    assign granted = arb_state_ff == EBA_OWNED;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gnt_n_ff <= EBA_GNT_RST;
        end else begin
            for (int i = 0; i < EBA_NUM_MASTERS; i++) begin
                gnt_n_ff[i] <= ~(granted && owner_ff == 2'(i)
                                 && !external_arbiter_mode);
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            shared_out_n_ff <= EBA_SHARED_OUT_RST;
        end else if (external_arbiter_mode) begin
            shared_out_n_ff <= ~own_bus_request;
        end else begin
            shared_out_n_ff <= ~(granted
                                 && owner_ff == EBA_SHARED_IDX);
        end
    end

    assign master_bus_grant_n = gnt_n_ff;
    assign shared_grant_or_request_out_n = shared_out_n_ff;
    // in external mode the shared input is the external arbiter's grant
    assign own_bus_granted = external_arbiter_mode
                             & ~syn.shared_in_n;

    // ==================================================
    // inbound target handshake
    eba_tgt_state_t tgt_state_ff;
    logic hold_n_ff;
    logic burst_ff;
    logic [3:0] lane_ff;
    logic start_ff;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tgt_state_ff <= EBA_T_IDLE;
            start_ff <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            unique case (tgt_state_ff)
                EBA_T_IDLE: begin
                    if (!syn.target_select_n) begin
                        tgt_state_ff <= EBA_T_HOLD;
                        start_ff <= 1'b1;
                    end
                end
                EBA_T_HOLD: begin
                    if (syn.target_select_n) begin
                        tgt_state_ff <= EBA_T_IDLE;
                    end else if (inbound_data_ready) begin
                        tgt_state_ff <= EBA_T_READY;
                    end
                end
                EBA_T_READY: begin
                    if (syn.target_select_n) begin
                        tgt_state_ff <= EBA_T_IDLE;
                    end
                end
                default: begin
                    tgt_state_ff <= EBA_T_IDLE;
                end
            endcase
        end
    end

    // burst and lanes captured at access start
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            burst_ff <= 1'b0;
            lane_ff <= 4'hF;
        end else if (tgt_state_ff == EBA_T_IDLE && !syn.target_select_n) begin
            burst_ff <= ~syn.burst;
            // reads always take the whole word
            lane_ff <= inbound_write ? ~syn.be_n : 4'hF;
        end
    end

    // hold-off low until the internal side has the data
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hold_n_ff <= EBA_WAIT_RST;
        end else begin
            hold_n_ff <= !(!syn.target_select_n
                           && tgt_state_ff != EBA_T_READY
                           && !(tgt_state_ff == EBA_T_HOLD
                                && inbound_data_ready));
        end
    end

    assign target_hold_off_n_out = hold_n_ff;
    assign target_hold_off_n_oe = ~syn.target_select_n;
    assign inbound_start = start_ff;
    assign inbound_burst = burst_ff;
    assign inbound_lane_mask = lane_ff;

    // ==================================================
    // checks
    one_grant_a: assert property (@(posedge clock) disable iff (sys_rst)
        $onehot0({~gnt_n_ff, ~shared_out_n_ff} &
                 {4{~external_arbiter_mode}}))
        else $error("more than one grant active");
    grant_cause_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(gnt_n_ff[0]) |-> $past(req_vec[0], 2))
        else $error("grant without request");
    quiet_switch_a: assert property (@(posedge clock) disable iff (sys_rst)
        (arb_state_ff == EBA_IDLE && !bus_quiet) |=> arb_state_ff == EBA_IDLE)
        else $error("arbitration during outbound cycle");
    hold_grant_a: assert property (@(posedge clock) disable iff (sys_rst)
        (granted && req_vec[owner_ff]) |=> granted && $stable(owner_ff))
        else $error("grant dropped while requested");
    drive_window_a: assert property (@(posedge clock) disable iff (sys_rst)
        syn.target_select_n |=> target_hold_off_n_out)
        else $error("hold-off driven while deselected");
    hold_low_a: assert property (@(posedge clock) disable iff (sys_rst)
        (tgt_state_ff == EBA_T_HOLD && !syn.target_select_n
         && !inbound_data_ready) |=> !hold_n_ff)
        else $error("hold-off released before data");
    ext_request_a: assert property (@(posedge clock) disable iff (sys_rst)
        external_arbiter_mode ##1 external_arbiter_mode |->
        shared_out_n_ff == !$past(own_bus_request))
        else $error("request not forwarded");
    ext_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        external_arbiter_mode ##1 external_arbiter_mode |-> &gnt_n_ff)
        else $error("grant in external mode");
    start_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
        start_ff |-> !$past(syn.target_select_n) ##1 !start_ff)
        else $error("bad start pulse");
endmodule
`default_nettype wire

// ---- tb/eba_ext_master.sv ----
// behavioural external masters, board pull-ups and wait pad
`timescale 1ns/10ps
`default_nettype none
module eba_ext_master (
    input wire logic clock,
    input wire logic [2:0] want_bus,
    input wire logic want_shared,
    input wire logic pullup_en,
    input wire logic hold_out,
    input wire logic hold_oe,
    output logic [2:0] req_pin_n,
    output logic shared_pin_n,
    output logic select_n,
    output logic burst_pin,
    output logic wait_pin
);
    // ========================================
    // pins
    // undriven lines read high through pull-ups
    assign req_pin_n = pullup_en ? 3'h7 : ~want_bus;
    assign shared_pin_n = ~want_shared;
    assign wait_pin = hold_oe ? hold_out : 1'h1;
    initial begin
        select_n = 1'h1;
        burst_pin = 1'h1;
    end
    // ========================================
    // inbound access, stalls while wait is low
    task automatic access(input logic burst, output logic ok);
        int n;
        logic seen;
        n = 0;
        select_n = 1'h0;
        burst_pin = burst;
        while (wait_pin !== 1'h0 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        seen = (wait_pin === 1'h0);
        while (wait_pin !== 1'h1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        ok = seen && (wait_pin === 1'h1);
        @(posedge clock);
        #1;
        select_n = 1'h1;
        burst_pin = 1'h1;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the expansion bus arbiter and target
`timescale 1ns/10ps
`default_nettype none
module tb;
    import eba_pkg::*;
    logic clock, sys_rst, mode, own_req, wr, ready, shared_pin, sel_n;
    logic want_sh, pu_en, sh_out, own_gnt, start, burst, hold, hold_oe;
    logic burst_pin, wait_pin;
    logic [2:0] want, req_n, gnt_n;
    logic [7:0] cs_n;
    logic [3:0] be_n, mask, gv, last_gv = 4'hF;
    logic [3:0] grant_q[$];
    logic [4:0] acc_q[$];
    logic [3:0] exp_g;
    logic [4:0] exp_a;
    int seed, mismatches = 0, tests_run = 0;
    eba_top dut (.clock(clock), .sys_rst(sys_rst),
        .external_arbiter_mode(mode), .master_bus_request_n(req_n),
        .master_bus_grant_n(gnt_n), .request_pullup_en(pu_en),
        .shared_request_or_grant_in_n(shared_pin),
        .shared_grant_or_request_out_n(sh_out), .own_bus_request(own_req),
        .own_bus_granted(own_gnt), .outbound_chip_select_n(cs_n),
        .target_select_n(sel_n), .inbound_burst_flag(burst_pin),
        .inbound_write(wr), .byte_lane_enable_n(be_n),
        .inbound_start(start), .inbound_burst(burst),
        .inbound_lane_mask(mask), .inbound_data_ready(ready),
        .target_hold_off_n_out(hold), .target_hold_off_n_oe(hold_oe));
    eba_ext_master master (.clock(clock), .want_bus(want),
        .want_shared(want_sh), .pullup_en(pu_en), .hold_out(hold),
        .hold_oe(hold_oe), .req_pin_n(req_n), .shared_pin_n(shared_pin),
        .select_n(sel_n), .burst_pin(burst_pin), .wait_pin(wait_pin));
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // ========================================
    // compare and report
    task automatic compare(input logic [4:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic check_grant(input logic [3:0] got, exp);
        compare({1'h0, got}, {1'h0, exp}, "grant");
    endtask
    task automatic check_access(input logic [4:0] got, exp);
        compare(got, exp, "access");
    endtask
    task automatic check_pin(input logic [4:0] got, exp);
        compare(got, exp, "level");
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic step;
        @(posedge clock);
        #1;
    endtask
    // ========================================
    // monitors take the oldest note per result
    always @(posedge clock) begin
        gv = {sh_out, gnt_n};
        if (!sys_rst && !mode) begin
            if (gv !== 4'hF && gv !== last_gv) begin
                exp_g = grant_q.size() ? grant_q.pop_front() : 4'hF;
                check_grant(gv, exp_g);
            end
            if ($countones(~gv) > 1)
                check_grant(gv, 4'hF);
        end
        last_gv = gv;
        if (!sys_rst && start === 1'h1) begin
            exp_a = acc_q.size() ? acc_q.pop_front() : 5'h1F;
            check_access({burst, mask}, exp_a);
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_of_test;
    end
    // ========================================
    // scenarios
    task automatic release_owner;
        int n;
        n = 0;
        while (gv === 4'hF && n < 40) begin
            step;
            n++;
        end
        repeat (3) step;
        want = want & gv[2:0];
        want_sh = want_sh & gv[3];
        while (gv !== 4'hF && n < 80) begin
            step;
            n++;
        end
        step;
    endtask
    task automatic inbound_access;
        int d, n;
        logic b, ok;
        b = 1'($random(seed));
        wr = 1'($random(seed));
        be_n = 4'($random(seed));
        d = 1 + $unsigned($random(seed)) % 6;
        acc_q.push_back({~b, wr ? ~be_n : 4'hF});
        fork
            master.access(b, ok);
            begin
                n = 0;
                while (start !== 1'h1 && n < 50) begin
                    step;
                    n++;
                end
                repeat (d) begin
                    check_pin({4'h0, wait_pin}, 5'h00);
                    step;
                end
                ready = 1'h1;
                step;
                ready = 1'h0;
            end
        join
        check_pin({4'h0, ok}, 5'h01);
        repeat (3) step;
        check_pin({4'h0, hold_oe}, 5'h00);
    endtask
    initial begin
        seed = 83;
        {sys_rst, mode, own_req, wr, ready, want_sh} = 6'h20;
        cs_n = 8'hFF;
        be_n = 4'hF;
        want = 3'h0;
        repeat (16) step;
        check_pin({1'h0, sh_out, gnt_n}, 5'h0F);
        check_pin({hold_oe, start, mask[2:0]}, 5'h07);
        sys_rst = 1'h0;
        step;
        repeat (6) inbound_access();
        // pointer starts at 0, so the shared pin is third
        grant_q = '{4'hD, 4'hB, 4'h7, 4'hE};
        want = 3'h7;
        want_sh = 1'h1;
        repeat (4) release_owner();
        cs_n = ~(8'h01 << ($unsigned($random(seed)) % 8));
        want = 3'h1;
        repeat (20) step;
        check_pin({1'h0, sh_out, gnt_n}, 5'h0F);
        grant_q.push_back(4'hE);
        cs_n = 8'hFF;
        release_owner();
        check_pin({4'h0, grant_q.size() == 0}, 5'h01);
        sys_rst = 1'h1;
        mode = 1'h1;
        step;
        sys_rst = 1'h0;
        repeat (3) step;
        check_pin({4'h0, pu_en}, 5'h01);
        own_req = 1'h1;
        want = 3'h7;
        repeat (4) step;
        check_pin({1'h0, sh_out, gnt_n}, 5'h07);
        want_sh = 1'h1;
        repeat (4) step;
        check_pin({4'h0, own_gnt}, 5'h01);
        {own_req, want_sh, want} = 5'h00;
        repeat (4) step;
        check_pin({own_gnt, sh_out, gnt_n}, 5'h0F);
        end_of_test;
    end
endmodule
`default_nettype wire
